// ==== inc/kps_defs.svh ====
// Function
// - Each word is eight bits on the serial input, clocked only while select is low.
// - Decode each accepted word's address and load exactly one of five registers.
// - Registers hold frequency, gain, time constant, prescaler, test and channel select.
// - Six-bit frequency code indexes a 64-entry centre frequency table.
// - Five-bit time-constant code indexes a 32-entry integrator table.
// - Prescaler codes 0 to 8 pick 4 to 24 MHz; fifth bit ignored.
// - Serial output floats when the float bit is 1, driven when 0.
// - Diagnostic mode outputs a register, buffered serial input, or comparator.
// - On select rising after a valid sequence, copy buffered word to register.
// - In integrate mode any single byte passing the filter is acted upon.
// - The filter accepts only words of exactly eight bits.
// - Most significant bit first, sampled on falling clock while select is low.
// - Prefix 00 frequency, 10 gain, 110 time constant; six, six, five bits.
// - Prefix 01 carries five prescaler bits then the float bit last.
// - Prefix 111: low bit picks channel, other four bits pick diagnostic mode.
`ifndef KPS_DEFS_SVH
`define KPS_DEFS_SVH
`define KPS_WORD_BITS     8
`define KPS_CNT_W         4
`define KPS_CNT_OVER      4'hf
`define KPS_PRE_MAX       4'h8
`define KPS_FREQ_RST      6'h00
`define KPS_GAIN_RST      6'h00
`define KPS_TC_RST        5'h00
`define KPS_PRE_RST       4'h0
`define KPS_SPARE_RST     1'h0
`define KPS_DIAG_RST      4'h0
`define KPS_CHAN_RST      1'h0
`define KPS_FLOAT_RST     1'h1
`define KPS_TEST_RST      5'h00
`define KPS_DIAG_FREQ     4'h1
`define KPS_DIAG_GAIN     4'h2
`define KPS_DIAG_TC       4'h3
`define KPS_DIAG_PRE      4'h4
`define KPS_DIAG_TEST     4'h5
`define KPS_DIAG_SI       4'h6
`define KPS_DIAG_CMP      4'h7
`endif

// ==== inc/kps_pkg.sv ====
package kps_pkg;
	typedef enum logic [2:0] {
		KPS_TGT_NONE,
		KPS_TGT_FREQ,
		KPS_TGT_GAIN,
		KPS_TGT_TC,
		KPS_TGT_PRE,
		KPS_TGT_TEST
	} kps_tgt_e;

	typedef enum logic [1:0] {
		KPS_IDLE,
		KPS_SHIFT,
		KPS_BAD
	} kps_state_e;

	// Decoded configuration as seen by the analog side.
	typedef struct packed {
		logic [5:0] freq_code;
		logic [5:0] gain_code;
		logic [4:0] tc_code;
		logic [3:0] prescale_code;
		logic       unused_prescale_bit;
		logic       out_float;
		logic [3:0] diag_mode;
		logic       channel_pick_bit;
	} kps_cfg_s;
endpackage

// ==== verification/kps_host_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module kps_host_model (
	// Clock.
	input  wire logic sys_clk,
	// Serial link.
	output logic      sck,
	output logic      cs_n,
	output logic      si
);
	// Idle link: clock low and the device not selected.
	initial {sck, cs_n, si} = 3'b010;
	task automatic tick(input int k);
		repeat (k) @(posedge sys_clk);
	endtask
	// Sends n bits MSB first; bad raises the clock before select falls.
	task automatic frame(input logic [8:0] w, input int n, input bit bad);
		tick(1);
		sck <= bad;
		tick(2);
		cs_n <= 1'b0;
		tick(2);
		sck <= 1'b0;
		tick(2);
		for (int i = n - 1; i >= 0; i--) begin
			si <= w[i];
			sck <= 1'b1;
			tick(2);
			sck <= 1'b0;
			tick(2);
		end
		cs_n <= 1'b1;
		si <= ~si; // A released line must not keep showing the last bit.
	endtask
endmodule
`default_nettype wire

// ==== verification/kps_spi_config_chk.sv ====
`timescale 1ns/1ps
`default_nettype none
module kps_spi_config_chk (
	// Clock and reset.
	input wire logic              sys_clk,
	input wire logic              rst,
	// Watched pins.
	input wire logic              cs_n,
	input wire logic              rect_cmp,
	input wire logic              so_o,
	input wire logic              so_oe,
	input wire kps_pkg::kps_cfg_s cfg,
	input wire logic              prescale_valid,
	input wire logic              load_pulse
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (rst);
	// Load strobe and its cause.
	property p_pulse; load_pulse |=> !load_pulse; endproperty
	a_pulse: assert property (p_pulse) else $error("long load");
	property p_load; !$stable(cfg) |-> load_pulse; endproperty
	a_load: assert property (p_load) else $error("no load");
	property p_cs; load_pulse |-> $past(cs_n); endproperty
	a_cs: assert property (p_cs) else $error("load in frame");
	property p_hold; !cs_n [*3] |=> $stable(cfg); endproperty
	a_hold: assert property (p_hold) else $error("cfg moved");
	// Output pin, its enable and prescale_valid follow their sources one cycle later.
	property p_oe; 1'b1 |-> so_oe == !$past(cfg.out_float); endproperty
	a_oe: assert property (p_oe) else $error("so_oe wrong");
	property p_pv; 1'b1 |-> prescale_valid == ($past(cfg.prescale_code) <= 4'h8);
	endproperty
	a_pv: assert property (p_pv) else $error("valid wrong");
	property p_cmp; $past(cfg.diag_mode) == 4'h7 |-> so_o == $past(rect_cmp);
	endproperty
	a_cmp: assert property (p_cmp) else $error("so_o cmp");
	property p_frq; $past(cfg.diag_mode) == 4'h1 |-> so_o == $past(cfg.freq_code[0]);
	endproperty
	a_frq: assert property (p_frq) else $error("so_o freq");
endmodule
bind kps_spi_config kps_spi_config_chk u_chk (.*);
`default_nettype wire

// ==== verification/tb_top.sv ====
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	logic              sys_clk, rst, int_hold, rect_cmp, sck, cs_n, si;
	logic              so_o, so_oe, prescale_valid, load_pulse;
	kps_pkg::kps_cfg_s cfg, exp_cfg;
	int                err_count, checked, loads;
	always #25 sys_clk = ~sys_clk;
	// Counting loads proves that a dropped frame left no trace.
	always @(posedge sys_clk) if (load_pulse) loads++;
	kps_spi_config dut (.sys_clk, .rst, .sck, .cs_n, .si, .int_hold, .rect_cmp,
		.so_o, .so_oe, .cfg, .prescale_valid, .load_pulse);
	kps_host_model host (.sys_clk, .sck, .cs_n, .si);
	task automatic check(input logic [31:0] got, exp);
		#1;
		checked++;
		if (got !== exp) begin
			err_count++;
			$display("Error %0t: got %h want %h", $time, got, exp);
		end
	endtask
	task automatic tick(input int k);
		repeat (k) @(posedge sys_clk);
	endtask
	// One frame, then loads, cfg, so_oe and prescale_valid against our own decode.
	task automatic send(input logic [8:0] w, input int n, input bit bad);
		int l0;
		l0 = loads;
		host.frame(w, n, bad);
		tick(10);
		if (n == 8 && !bad) begin
			l0++;
			casez (w[7:0])
			8'b00??????: exp_cfg.freq_code = w[5:0];
			8'b10??????: exp_cfg.gain_code = w[5:0];
			8'b110?????: exp_cfg.tc_code = w[4:0];
			8'b01??????: {exp_cfg.unused_prescale_bit, exp_cfg.prescale_code,
				exp_cfg.out_float} = w[5:0];
			default: {exp_cfg.diag_mode, exp_cfg.channel_pick_bit} = w[4:0];
			endcase
		end
		check(loads, l0);
		check(cfg, exp_cfg);
		check(so_oe, !exp_cfg.out_float);
		check(prescale_valid, exp_cfg.prescale_code <= 4'h8);
		tick(1);
	endtask
	task automatic s_words;
		int_hold <= 1'b1;
		send(9'h02b, 8, 0);
		send(9'h094, 8, 0);
		int_hold <= 1'b0;
		send(9'h0c3, 8, 0);
		send(9'h070, 8, 0);
		send(9'h052, 8, 0);
		int_hold <= 1'b1;
		send(9'h050, 8, 0);
	endtask
	// Short, long and badly framed words must all be dropped.
	task automatic s_bad;
		send(9'h03f, 7, 0);
		send(9'h13f, 9, 0);
		send(9'h03f, 8, 1);
	endtask
	task automatic s_diag;
		send(9'h0ef, 8, 0);
		rect_cmp <= 1'b1;
		tick(3);
		check(so_o, 1'b1);
		tick(1);
		rect_cmp <= 1'b0;
		tick(3);
		check(so_o, 1'b0);
		send(9'h0e2, 8, 0);
		check(so_o, exp_cfg.freq_code[0]);
		send(9'h0e4, 8, 0);
		check(so_o, exp_cfg.gain_code[0]);
		send(9'h0e6, 8, 0);
		check(so_o, exp_cfg.tc_code[0]);
		send(9'h0e8, 8, 0);
		check(so_o, exp_cfg.prescale_code[0]);
		send(9'h0eb, 8, 0);
		check(so_o, exp_cfg.channel_pick_bit);
		send(9'h0ec, 8, 0);
		check(so_o, si);
	endtask
	task automatic final_report;
		if (err_count == 0 && checked > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	// A hung wait ends the run as a failure.
	initial begin
		#200000;
		err_count++;
		final_report;
	end
	initial begin
		{sys_clk, rst, int_hold, rect_cmp} = 4'b0100;
		exp_cfg = '0;
		exp_cfg.out_float = 1'b1;
		tick(2);
		rst <= 1'b0;
		check(cfg, exp_cfg);
		tick(1);
		s_words;
		s_bad;
		s_diag;
		final_report;
	end
endmodule
`default_nettype wire

// ==== verilog/kps_spi_config.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "kps_defs.svh"
module kps_spi_config (
	// Clock and reset.
	input  wire logic         sys_clk,
	input  wire logic         rst,
	// Serial link from the host, sampled on sys_clk.
	input  wire logic         sck,
	input  wire logic         cs_n,
	input  wire logic         si,
	// Analog side status.
	input  wire logic         int_hold,
	input  wire logic         rect_cmp,
	// Serial output pin.
	output logic              so_o,
	output logic              so_oe,
	// Configuration.
	output kps_pkg::kps_cfg_s cfg,
	output logic              prescale_valid,
	output logic              load_pulse
);
	logic                  sck_d_r;
	logic                  cs_d_r;
	logic [7:0]            shift_r;
	logic [`KPS_CNT_W-1:0] cnt_r;
	kps_pkg::kps_state_e   state_r;
	kps_pkg::kps_cfg_s     cfg_r;
	logic                  so_r;
	logic                  so_oe_r;
	logic                  pv_r;
	logic                  load_r;
	logic                  sck_fall;
	logic                  sck_rise;
	logic                  cs_fall;
	logic                  cs_rise;
	logic                  word_ok;
	kps_pkg::kps_tgt_e     tgt;

	// Address decode of a finished word, used only by the loader.
	function automatic kps_pkg::kps_tgt_e decode(input logic [7:0] w);
		kps_pkg::kps_tgt_e t;
		t = kps_pkg::KPS_TGT_NONE;
		unique casez (w[7:5])
			3'b00?: t = kps_pkg::KPS_TGT_FREQ;
			3'b10?: t = kps_pkg::KPS_TGT_GAIN;
			3'b110: t = kps_pkg::KPS_TGT_TC;
			3'b01?: t = kps_pkg::KPS_TGT_PRE;
			3'b111: t = kps_pkg::KPS_TGT_TEST;
		endcase
		return t;
	endfunction

	// Edge detection; the pins are taken as synchronous to sys_clk.
	assign sck_fall = sck_d_r & ~sck;
	assign sck_rise = ~sck_d_r & sck;
	assign cs_fall  = cs_d_r & ~cs_n;
	assign cs_rise  = ~cs_d_r & cs_n;
	assign tgt      = decode(shift_r);
	// A word counts only with exactly eight pulses and the clock low.
	assign word_ok  = (state_r == kps_pkg::KPS_SHIFT) && cs_rise &&
		(cnt_r == `KPS_CNT_W'(`KPS_WORD_BITS)) && !sck;

	// Previous pin levels.
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			sck_d_r <= 1'b0;
			cs_d_r  <= 1'b1;
		end else begin
			sck_d_r <= sck;
			cs_d_r  <= cs_n;
		end
	end

	// Frame tracking: a clock high at select fall poisons the frame.
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			state_r <= kps_pkg::KPS_IDLE;
		end else if (cs_n) begin
			state_r <= kps_pkg::KPS_IDLE;
		end else if (cs_fall) begin
			state_r <= sck ? kps_pkg::KPS_BAD : kps_pkg::KPS_SHIFT;
		end
	end

	// Shifter: MSB first on each falling clock while selected.
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			shift_r <= 8'h00;
		end else if (!cs_n && sck_fall) begin
			shift_r <= {shift_r[6:0], si};
		end
	end

	// Pulse counter saturates so that long frames stay invalid.
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			cnt_r <= `KPS_CNT_W'(0);
		end else if (cs_fall) begin
			cnt_r <= `KPS_CNT_W'(0);
		end else if (!cs_n && sck_rise && cnt_r != `KPS_CNT_OVER) begin
			cnt_r <= cnt_r + `KPS_CNT_W'(1);
		end
	end

	// Register load on select rise; int_hold does not block loading.
	// Only one target is written, so others keep their values.
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			cfg_r.freq_code           <= `KPS_FREQ_RST;
			cfg_r.gain_code           <= `KPS_GAIN_RST;
			cfg_r.tc_code             <= `KPS_TC_RST;
			cfg_r.prescale_code       <= `KPS_PRE_RST;
			cfg_r.unused_prescale_bit <= `KPS_SPARE_RST;
			cfg_r.out_float           <= `KPS_FLOAT_RST;
			cfg_r.diag_mode           <= `KPS_DIAG_RST;
			cfg_r.channel_pick_bit    <= `KPS_CHAN_RST;
		end else if (word_ok) begin
			unique case (tgt)
				kps_pkg::KPS_TGT_FREQ: cfg_r.freq_code <= shift_r[5:0];
				kps_pkg::KPS_TGT_GAIN: cfg_r.gain_code <= shift_r[5:0];
				kps_pkg::KPS_TGT_TC: cfg_r.tc_code <= shift_r[4:0];
				kps_pkg::KPS_TGT_PRE: begin
					cfg_r.unused_prescale_bit <= shift_r[5];
					cfg_r.prescale_code       <= shift_r[4:1];
					cfg_r.out_float           <= shift_r[0];
				end
				kps_pkg::KPS_TGT_TEST: begin
					cfg_r.diag_mode        <= shift_r[4:1];
					cfg_r.channel_pick_bit <= shift_r[0];
				end
				kps_pkg::KPS_TGT_NONE: begin
				end
			endcase
		end
	end

	// Load strobe and prescaler legality flag.
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			load_r <= 1'b0;
			pv_r   <= 1'b1;
		end else begin
			load_r <= word_ok;
			pv_r   <= (cfg_r.prescale_code <= `KPS_PRE_MAX);
		end
	end

	// Serial output: diagnostic mux, registers shown as parity-free LSB.
	// A single pin can show one bit, so each register's low bit is used.
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			so_r    <= 1'b0;
			so_oe_r <= 1'b0;
		end else begin
			so_oe_r <= ~cfg_r.out_float;
			unique case (cfg_r.diag_mode)
				`KPS_DIAG_FREQ: so_r <= cfg_r.freq_code[0];
				`KPS_DIAG_GAIN: so_r <= cfg_r.gain_code[0];
				`KPS_DIAG_TC:   so_r <= cfg_r.tc_code[0];
				`KPS_DIAG_PRE:  so_r <= cfg_r.prescale_code[0];
				`KPS_DIAG_TEST: so_r <= cfg_r.channel_pick_bit;
				`KPS_DIAG_SI:   so_r <= si;
				`KPS_DIAG_CMP:  so_r <= rect_cmp;
				default:        so_r <= 1'b0;
			endcase
		end
	end

	assign so_o           = so_r;
	assign so_oe          = so_oe_r;
	assign cfg            = cfg_r;
	assign prescale_valid = pv_r;
	assign load_pulse     = load_r;
endmodule
`default_nettype wire
